// file: literal_and_indirect_move_exec.sv
/*
 Execution logic for literal loads, direct and indirect stores of the
 working register, option load, no-operation and software reset.
 Assumes one decoded instruction per cycle of ref_clk, data memory that
 takes a write in the cycle mem_wr.we is high, and a register port with
 one-cycle strobes that never overlap.
*/
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "move_exec_regs.svh"
// Summary of operation
// - Bank load copies literal into bank select, flags untouched
// - Page load copies literal into program counter high latch
// - Work load places eight-bit literal into working register
// - Direct store writes working register to addressed file register
// - Indirect store writes working register at pointer-derived address
// - Mode code: 00 preinc, 01 predec, 10 postinc, 11 postdec
// - Pointer ends plus one, minus one, or unchanged for offset form
// - Pointers are sixteen bits and wrap at both ends
// - Pointer stepping never alters any status bit
// - Window addresses hold nothing; they redirect through the pointer
// - Option load copies working register into option register
// - Software reset resets device and asserts reset-instruction flag
module literal_and_indirect_move_exec (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire move_exec_pkg::instr_t instr,
	input  wire logic [7:0]            bus_addr,
	input  wire logic [7:0]            bus_wdata,
	input  wire logic                  bus_wr,
	input  wire logic                  bus_rd,
	output logic [7:0]                 bus_rdata,
	output var move_exec_pkg::mem_wr_t mem_wr,
	output logic                       instr_done,
	output logic                       soft_reset_pulse,
	output logic [4:0]                 bank_select_register,
	output logic [6:0]                 program_counter_high_latch,
	output logic [7:0]                 work,
	output logic [7:0]                 option_config,
	output logic [15:0]                indirect_pointer0,
	output logic [15:0]                indirect_pointer1,
	output logic [7:0]                 status_bits,
	output logic                       reset_instruction_flag_n
);

	logic [4:0]             next_bank;
	logic [6:0]             next_page;
	logic [7:0]             next_work;
	logic [7:0]             next_option;
	logic [15:0]            next_ptr0;
	logic [15:0]            next_ptr1;
	logic [7:0]             next_status;
	logic                   next_flag_n;
	logic                   next_done;
	logic                   next_sreset;
	move_exec_pkg::mem_wr_t next_mem;
	logic [7:0]             next_rdata;
	logic [15:0]            sel_ptr;
	logic [15:0]            stepped;
	logic [15:0]            offset_ext;

	always_comb begin
		next_bank   = bank_select_register;
		next_page   = program_counter_high_latch;
		next_work   = work;
		next_option = option_config;
		next_ptr0   = indirect_pointer0;
		next_ptr1   = indirect_pointer1;
		next_status = status_bits;
		next_flag_n = reset_instruction_flag_n;
		next_done   = 1'b0;
		next_sreset = 1'b0;
		next_mem    = '0;
		sel_ptr     = instr.ptr_sel ? indirect_pointer1 : indirect_pointer0;
		offset_ext  = {{10{instr.offset[5]}}, instr.offset};
		// Wraps modulo 2^16 by width alone
		if (instr.pointer_mode_code[0]) begin
			stepped = sel_ptr - `PTR_STEP;
		end else begin
			stepped = sel_ptr + `PTR_STEP;
		end

		// Software access comes first so a same-cycle instruction wins
		if (bus_wr) begin
			if (bus_addr == `ADDR_BANK) begin
				next_bank = bus_wdata[4:0];
			end else if (bus_addr == `ADDR_PAGE) begin
				next_page = bus_wdata[6:0];
			end else if (bus_addr == `ADDR_WORK) begin
				next_work = bus_wdata;
			end else if (bus_addr == `ADDR_OPTION) begin
				next_option = bus_wdata;
			end else if (bus_addr == `ADDR_PTR0_LO) begin
				next_ptr0[7:0] = bus_wdata;
			end else if (bus_addr == `ADDR_PTR0_HI) begin
				next_ptr0[15:8] = bus_wdata;
			end else if (bus_addr == `ADDR_PTR1_LO) begin
				next_ptr1[7:0] = bus_wdata;
			end else if (bus_addr == `ADDR_PTR1_HI) begin
				next_ptr1[15:8] = bus_wdata;
			end else if (bus_addr == `ADDR_STATUS) begin
				next_status = bus_wdata;
			end else if (bus_addr == `ADDR_POWER) begin
				next_flag_n = bus_wdata[`RI_FLAG_BIT];
			end
		end

		if (instr.valid) begin
			next_done = 1'b1;
			case (instr.op)
				move_exec_pkg::op_load_bank: begin
					next_bank = instr.literal[4:0];
				end
				move_exec_pkg::op_load_page: begin
					next_page = instr.literal[6:0];
				end
				move_exec_pkg::op_load_work: begin
					next_work = instr.literal;
				end
				move_exec_pkg::op_store_file: begin
					next_mem.we   = 1'b1;
					next_mem.data = work;
					// Window addresses have no cell behind them
					if (instr.file_addr == `WINDOW0_ADDR) begin
						next_mem.addr = indirect_pointer0;
					end else if (instr.file_addr == `WINDOW1_ADDR) begin
						next_mem.addr = indirect_pointer1;
					end else begin
						next_mem.addr = {4'h0, bank_select_register,
							instr.file_addr};
					end
				end
				move_exec_pkg::op_store_indirect: begin
					next_mem.we   = 1'b1;
					next_mem.data = work;
					// Pre modes use the stepped value
					if (instr.pointer_mode_code[1]) begin
						next_mem.addr = sel_ptr;
					end else begin
						next_mem.addr = stepped;
					end
					// Status is never touched here
					if (instr.ptr_sel) begin
						next_ptr1 = stepped;
					end else begin
						next_ptr0 = stepped;
					end
				end
				move_exec_pkg::op_store_offset: begin
					next_mem.we   = 1'b1;
					next_mem.data = work;
					next_mem.addr = sel_ptr + offset_ext;
				end
				move_exec_pkg::op_load_option: begin
					next_option = work;
				end
				move_exec_pkg::op_soft_reset: begin
					// Same values as rst, except the cause flag
					next_bank   = `BANK_RST;
					next_page   = `PAGE_RST;
					next_work   = `WORK_RST;
					next_option = `OPTION_RST;
					next_ptr0   = `PTR_RST;
					next_ptr1   = `PTR_RST;
					next_status = `STATUS_RST;
					next_flag_n = 1'b0;
					next_sreset = 1'b1;
				end
				default: begin
					next_done = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bank_select_register       <= `BANK_RST;
			program_counter_high_latch <= `PAGE_RST;
			work                       <= `WORK_RST;
			option_config              <= `OPTION_RST;
			indirect_pointer0          <= `PTR_RST;
			indirect_pointer1          <= `PTR_RST;
			status_bits                <= `STATUS_RST;
			reset_instruction_flag_n   <= 1'b1;
			instr_done                 <= 1'b0;
			soft_reset_pulse           <= 1'b0;
			mem_wr                     <= '0;
		end else begin
			bank_select_register       <= next_bank;
			program_counter_high_latch <= next_page;
			work                       <= next_work;
			option_config              <= next_option;
			indirect_pointer0          <= next_ptr0;
			indirect_pointer1          <= next_ptr1;
			status_bits                <= next_status;
			reset_instruction_flag_n   <= next_flag_n;
			instr_done                 <= next_done;
			soft_reset_pulse           <= next_sreset;
			mem_wr                     <= next_mem;
		end
	end

	// Reads show state before any write in the same cycle
	always_comb begin
		next_rdata = 8'h00;
		if (bus_rd) begin
			if (bus_addr == `ADDR_BANK) begin
				next_rdata = {3'h0, bank_select_register};
			end else if (bus_addr == `ADDR_PAGE) begin
				next_rdata = {1'b0, program_counter_high_latch};
			end else if (bus_addr == `ADDR_WORK) begin
				next_rdata = work;
			end else if (bus_addr == `ADDR_OPTION) begin
				next_rdata = option_config;
			end else if (bus_addr == `ADDR_PTR0_LO) begin
				next_rdata = indirect_pointer0[7:0];
			end else if (bus_addr == `ADDR_PTR0_HI) begin
				next_rdata = indirect_pointer0[15:8];
			end else if (bus_addr == `ADDR_PTR1_LO) begin
				next_rdata = indirect_pointer1[7:0];
			end else if (bus_addr == `ADDR_PTR1_HI) begin
				next_rdata = indirect_pointer1[15:8];
			end else if (bus_addr == `ADDR_STATUS) begin
				next_rdata = status_bits;
			end else if (bus_addr == `ADDR_POWER) begin
				next_rdata = {7'h00, reset_instruction_flag_n};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus_rdata <= 8'h00;
		end else begin
			bus_rdata <= next_rdata;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_bank_load;
		instr.valid && instr.op == move_exec_pkg::op_load_bank
		|=> bank_select_register == $past(instr.literal[4:0])
			&& status_bits == $past(status_bits);
	endproperty
	a_bank_load: assert property (p_bank_load)
		else $error("bank select not loaded from literal");

	property p_page_load;
		instr.valid && instr.op == move_exec_pkg::op_load_page
		|=> program_counter_high_latch == $past(instr.literal[6:0]);
	endproperty
	a_page_load: assert property (p_page_load)
		else $error("page latch not loaded from literal");

	property p_work_load;
		instr.valid && instr.op == move_exec_pkg::op_load_work
		|=> work == $past(instr.literal) && $stable(status_bits);
	endproperty
	a_work_load: assert property (p_work_load)
		else $error("working register not loaded from literal");

	property p_store_file;
		instr.valid && instr.op == move_exec_pkg::op_store_file
			&& instr.file_addr > `WINDOW1_ADDR
		|=> mem_wr.we && mem_wr.data == $past(work)
			&& mem_wr.addr[6:0] == $past(instr.file_addr)
			&& mem_wr.addr[11:7] == $past(bank_select_register);
	endproperty
	a_store_file: assert property (p_store_file)
		else $error("direct store wrote wrong place or value");

	property p_preinc;
		instr.valid && instr.op == move_exec_pkg::op_store_indirect
			&& !instr.ptr_sel && instr.pointer_mode_code == `MODE_PREINC
			&& !bus_wr
		|=> mem_wr.addr == $past(indirect_pointer0) + `PTR_STEP
			&& indirect_pointer0 == mem_wr.addr;
	endproperty
	a_preinc: assert property (p_preinc)
		else $error("preincrement address or pointer wrong");

	property p_postdec;
		instr.valid && instr.op == move_exec_pkg::op_store_indirect
			&& instr.ptr_sel && instr.pointer_mode_code == `MODE_POSTDEC
			&& !bus_wr
		|=> mem_wr.addr == $past(indirect_pointer1)
			&& indirect_pointer1 == mem_wr.addr - `PTR_STEP;
	endproperty
	a_postdec: assert property (p_postdec)
		else $error("postdecrement address or pointer wrong");

	property p_offset;
		instr.valid && instr.op == move_exec_pkg::op_store_offset
			&& !bus_wr
		|=> $stable(indirect_pointer0) && $stable(indirect_pointer1)
			&& mem_wr.we && mem_wr.data == $past(work);
	endproperty
	a_offset: assert property (p_offset)
		else $error("offset store moved a pointer");

	property p_status_hold;
		instr.valid && instr.op != move_exec_pkg::op_soft_reset && !bus_wr
		|=> $stable(status_bits);
	endproperty
	a_status_hold: assert property (p_status_hold)
		else $error("status changed by a move");

	property p_window;
		instr.valid && instr.op == move_exec_pkg::op_store_file
			&& instr.file_addr == `WINDOW1_ADDR
		|=> mem_wr.addr == $past(indirect_pointer1);
	endproperty
	a_window: assert property (p_window)
		else $error("window store not redirected");

	property p_option;
		instr.valid && instr.op == move_exec_pkg::op_load_option
		|=> option_config == $past(work);
	endproperty
	a_option: assert property (p_option)
		else $error("option register not loaded");

	property p_soft_reset;
		instr.valid && instr.op == move_exec_pkg::op_soft_reset
		|=> soft_reset_pulse && !reset_instruction_flag_n
			&& work == `WORK_RST && option_config == `OPTION_RST
			##1 !soft_reset_pulse;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("software reset incomplete");

	property p_nop;
		instr.valid && instr.op == move_exec_pkg::op_nop && !bus_wr
		|=> !mem_wr.we && $stable(work) && $stable(indirect_pointer0)
			&& $stable(indirect_pointer1) && $stable(option_config);
	endproperty
	a_nop: assert property (p_nop)
		else $error("no-operation changed state");

	property p_back_to_back;
		instr.valid ##1 instr.valid |=> instr_done && $past(instr_done);
	endproperty
	a_back_to_back: assert property (p_back_to_back)
		else $error("instruction not done in one cycle");

	c_indirect: cover property (instr.valid
		&& instr.op == move_exec_pkg::op_store_indirect ##1 instr.valid
		&& instr.op == move_exec_pkg::op_store_indirect);
	c_window: cover property (instr.valid
		&& instr.op == move_exec_pkg::op_store_file
		&& instr.file_addr == `WINDOW0_ADDR);
	c_soft_reset: cover property (soft_reset_pulse);
	c_wrap: cover property (indirect_pointer0 == 16'hFFFF ##1
		indirect_pointer0 == 16'h0000);

endmodule
`default_nettype wire

// file: move_exec_regs.svh
/*
 Offsets, field positions and reset values for the move execution unit.
 Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef MOVE_EXEC_REGS_SVH
`define MOVE_EXEC_REGS_SVH

`define ADDR_BANK        8'h00
`define ADDR_PAGE        8'h04
`define ADDR_WORK        8'h08
`define ADDR_OPTION      8'h0C
`define ADDR_PTR0_LO     8'h10
`define ADDR_PTR0_HI     8'h14
`define ADDR_PTR1_LO     8'h18
`define ADDR_PTR1_HI     8'h1C
`define ADDR_STATUS      8'h20
`define ADDR_POWER       8'h24

`define RI_FLAG_BIT      0

`define BANK_RST         5'h00
`define PAGE_RST         7'h00
`define WORK_RST         8'h00
`define OPTION_RST       8'hFF
`define PTR_RST          16'h0000
`define STATUS_RST       8'h00
`define PTR_STEP         16'h0001

`define WINDOW0_ADDR     7'h00
`define WINDOW1_ADDR     7'h01

`define MODE_PREINC      2'h0
`define MODE_PREDEC      2'h1
`define MODE_POSTINC     2'h2
`define MODE_POSTDEC     2'h3

`endif

// file: move_exec_pkg.sv
/*
 Types shared by the move execution unit and its surroundings.
 Assumes the decoder fills instr_t once per instruction cycle.
*/
package move_exec_pkg;

	typedef enum logic [3:0] {
		op_nop,
		op_load_bank,
		op_load_page,
		op_load_work,
		op_store_file,
		op_store_indirect,
		op_store_offset,
		op_load_option,
		op_soft_reset
	} op_t;

	typedef struct packed {
		logic              valid;
		op_t               op;
		logic [7:0]        literal;
		logic [6:0]        file_addr;
		logic              ptr_sel;
		logic [1:0]        pointer_mode_code;
		logic signed [5:0] offset;
	} instr_t;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  data;
	} mem_wr_t;

endpackage

// file: data_mem_model.sv
/*
 Data memory model standing on the far side of the move execution unit.
 Assumes writes arrive as one-cycle mem_wr pulses sampled on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
	input  wire logic                   ref_clk,
	input  wire move_exec_pkg::mem_wr_t mem_wr,
	output logic [15:0]                 write_count
);
	logic [7:0] cells [logic [15:0]];

	initial write_count = 16'h0000;

	// Sparse store: a full 64K array would be wasted on a short run
	always @(posedge ref_clk) begin
		if (mem_wr.we === 1'b1) begin
			cells[mem_wr.addr] = mem_wr.data;
			write_count <= write_count + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// file: tb.sv
/*
 Self-checking bench for the move execution unit: drives decoded
 instructions and the register port, predicts results in queues.
 Assumes the design, its package and data_mem_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "move_exec_regs.svh"
module tb;
	logic                  ref_clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  bus_wr = 1'b0;
	logic                  bus_rd = 1'b0;
	logic                  rd_seen = 1'b0;
	logic [7:0]            bus_addr = 8'h00;
	logic [7:0]            bus_wdata = 8'h00;
	move_exec_pkg::instr_t instr = '0;
	logic [7:0]            bus_rdata;
	move_exec_pkg::mem_wr_t mem_wr;
	logic                  instr_done;
	logic                  soft_reset_pulse;
	logic [15:0]           write_count;
	logic [4:0]            bank_select_register;
	logic [6:0]            program_counter_high_latch;
	logic [7:0]            work;
	logic [7:0]            option_config;
	logic [15:0]           indirect_pointer0;
	logic [15:0]           indirect_pointer1;
	logic [7:0]            status_bits;
	logic                  reset_instruction_flag_n;
	logic [7:0]            st = 8'h00;
	logic                  flag_n = 1'b1;
	logic [7:0]            w = 8'h00;
	logic [7:0]            bank = 8'h00;
	logic [7:0]            page = 8'h00;
	logic [7:0]            opt = 8'hFF;
	logic [15:0]           p [2] = '{16'h0000, 16'h0000};
	logic [15:0]           rq [$];
	move_exec_pkg::mem_wr_t mq [$];
	int                    failures = 0;
	int                    comparisons = 0;
	int                    issued = 0;
	int                    dones = 0;
	int                    resets = 0;
	localparam logic [15:0] rst_tab [11] = '{16'h0000, 16'h0400, 16'h0800,
		16'h0CFF, 16'h1000, 16'h1400, 16'h1800, 16'h1C00, 16'h2000,
		16'h2401, 16'h2800};

	always #10 ref_clk = ~ref_clk;

	literal_and_indirect_move_exec literal_and_indirect_move_exec_inst (
		.ref_clk(ref_clk), .rst(rst), .instr(instr), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .mem_wr(mem_wr), .instr_done(instr_done),
		.soft_reset_pulse(soft_reset_pulse),
		.bank_select_register(bank_select_register),
		.program_counter_high_latch(program_counter_high_latch),
		.work(work), .option_config(option_config),
		.indirect_pointer0(indirect_pointer0),
		.indirect_pointer1(indirect_pointer1),
		.status_bits(status_bits),
		.reset_instruction_flag_n(reset_instruction_flag_n));

	data_mem_model data_mem_model_inst (
		.ref_clk(ref_clk), .mem_wr(mem_wr), .write_count(write_count));

	task automatic end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected value at %0t: %h vs %h", $time, got, exp);
		end
	endtask

	task automatic chk_wr(input move_exec_pkg::mem_wr_t got,
		input move_exec_pkg::mem_wr_t exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected write at %0t: %h vs %h", $time, got, exp);
		end
	endtask

	task automatic drive(input logic v, input move_exec_pkg::op_t o,
		input logic [7:0] l, input logic [6:0] f, input logic s,
		input logic [1:0] m, input logic [5:0] k, input logic wr,
		input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		instr <= '{v, o, l, f, s, m, k};
		bus_wr <= wr;
		bus_rd <= rd;
		bus_addr <= a;
		bus_wdata <= d;
	endtask

	task automatic op(input move_exec_pkg::op_t o, input logic [7:0] l = 0,
		input logic [6:0] f = 0, input logic s = 0,
		input logic [1:0] m = 0, input logic [5:0] k = 0);
		issued++;
		drive(1'b1, o, l, f, s, m, k, 1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic idle;
		drive(1'b0, move_exec_pkg::op_nop, 0, 0, 0, 0, 0, 0, 0, 0, 0);
	endtask

	task automatic bw(input logic [7:0] a, input logic [7:0] d);
		drive(1'b0, move_exec_pkg::op_nop, 0, 0, 0, 0, 0, 1'b1, 0, a, d);
	endtask

	task automatic br(input logic [7:0] a, input logic [7:0] e);
		rq.push_back({8'h00, e});
		drive(1'b0, move_exec_pkg::op_nop, 0, 0, 0, 0, 0, 0, 1'b1, a, 0);
	endtask

	task automatic regs;
		// Mid-cycle, so the last instruction's results have settled
		@(negedge ref_clk);
		chk_val(16'(bank_select_register), 16'(bank));
		chk_val(16'(program_counter_high_latch), 16'(page));
		chk_val(16'(work), 16'(w));
		chk_val(16'(option_config), 16'(opt));
		chk_val(indirect_pointer0, p[0]);
		chk_val(indirect_pointer1, p[1]);
		chk_val(16'(status_bits), 16'(st));
		chk_val(16'(reset_instruction_flag_n), 16'(flag_n));
		br(`ADDR_BANK, bank);
		br(`ADDR_PAGE, page);
		br(`ADDR_WORK, w);
		br(`ADDR_OPTION, opt);
		br(`ADDR_PTR0_LO, p[0][7:0]);
		br(`ADDR_PTR0_HI, p[0][15:8]);
		br(`ADDR_PTR1_LO, p[1][7:0]);
		br(`ADDR_PTR1_HI, p[1][15:8]);
		br(`ADDR_STATUS, st);
	endtask

	task automatic ind(input logic s, input logic [1:0] m);
		logic [15:0] a;
		a = m[1] ? p[s] : (m[0] ? p[s] - 16'h0001 : p[s] + 16'h0001);
		p[s] = m[0] ? p[s] - 16'h0001 : p[s] + 16'h0001;
		mq.push_back('{1'b1, a, w});
		op(move_exec_pkg::op_store_indirect, 0, 0, s, m);
	endtask

	task automatic sf(input logic [6:0] f);
		logic [15:0] a;
		a = (f == 7'h00) ? p[0] : (f == 7'h01) ? p[1] : {4'h0, bank[4:0], f};
		mq.push_back('{1'b1, a, w});
		op(move_exec_pkg::op_store_file, 0, f);
	endtask

	task automatic so(input logic s, input logic [5:0] k);
		mq.push_back('{1'b1, p[s] + {{10{k[5]}}, k}, w});
		op(move_exec_pkg::op_store_offset, 0, 0, s, 0, k);
	endtask

	always @(posedge ref_clk) rd_seen <= bus_rd;

	// Sampled mid-cycle so registered outputs have settled
	always @(negedge ref_clk) begin
		if (rd_seen === 1'b1)
			chk_val({8'h00, bus_rdata}, rq.size() ? rq.pop_front() : '1);
		if (mem_wr.we !== 1'b0)
			chk_wr(mem_wr, mq.size() ? mq.pop_front() : '0);
		if (instr_done === 1'b1)
			dones++;
		if (soft_reset_pulse === 1'b1)
			resets++;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		end_sim;
	end

	initial begin
		void'($urandom(98));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (rst_tab[i]) br(rst_tab[i][15:8], rst_tab[i][7:0]);
		repeat (3) begin
			bank = 8'($urandom_range(15));
			op(move_exec_pkg::op_load_bank, bank);
			page = 8'($urandom_range(127));
			op(move_exec_pkg::op_load_page, page);
			w = 8'($urandom);
			op(move_exec_pkg::op_load_work, w);
		end
		idle;
		regs;
		p[0] = 16'hFFFF;
		bw(`ADDR_PTR0_LO, 8'hFF);
		bw(`ADDR_PTR0_HI, 8'hFF);
		foreach (rst_tab[i]) begin
			w = 8'($urandom);
			op(move_exec_pkg::op_load_work, w);
			sf(i < 2 ? 7'(i) : (i == 10 ? 7'h7F : 7'($urandom)));
		end
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 4; m++) begin
				w = 8'($urandom);
				op(move_exec_pkg::op_load_work, w);
				ind(s[0], m[1:0]);
			end
			so(s[0], 6'h20);
			so(s[0], 6'h1F);
		end
		op(move_exec_pkg::op_load_option);
		opt = w;
		op(move_exec_pkg::op_nop);
		idle;
		regs;
		chk_val(16'(dones), 16'(issued));
		chk_val(write_count, 16'h0017);
		chk_val({8'h00, data_mem_model_inst.cells[p[1] + 16'h001F]}, {8'h00, w});
		// Every writable address from software except ADDR_POWER; narrow ones drop upper bits
		{bank, page, w, opt} = $urandom;
		st = 8'($urandom);
		p = '{16'($urandom), 16'($urandom)};
		bw(`ADDR_BANK, bank);
		bw(`ADDR_PAGE, page);
		bw(`ADDR_WORK, w);
		bw(`ADDR_OPTION, opt);
		bw(`ADDR_PTR0_LO, p[0][7:0]);
		bw(`ADDR_PTR0_HI, p[0][15:8]);
		bw(`ADDR_PTR1_LO, p[1][7:0]);
		bw(`ADDR_PTR1_HI, p[1][15:8]);
		bw(`ADDR_STATUS, st);
		{bank, page} = {bank & 8'h1F, page & 8'h7F};
		idle;
		regs;
		// Same-cycle bus write must lose to the software reset
		issued++;
		drive(1'b1, move_exec_pkg::op_soft_reset, 0, 0, 0, 0, 0, 1'b1, 0,
			`ADDR_POWER, 8'h01);
		{w, bank, page, opt} = {8'h00, 8'h00, 8'h00, 8'hFF};
		p = '{16'h0000, 16'h0000};
		{st, flag_n} = {8'h00, 1'b0};
		idle;
		regs;
		br(`ADDR_POWER, 8'h00);
		bw(`ADDR_POWER, 8'h01);
		br(`ADDR_POWER, 8'h01);
		idle;
		idle;
		chk_val(16'(resets), 16'h0001);
		chk_val(16'(rq.size() + mq.size()), 16'h0000);
		end_sim;
	end
endmodule
`default_nettype wire
